/* File: core/trcc_csr.sv */
// Machine and supervisor transfer record control registers with recorder filter
`timescale 1ns/100ps

module trcc_csr
	import trcc_pkg::*;
#(
	parameter int XLEN = 64, // Register width of the hart, 64 or 32
	parameter bit HAS_OVF_IRQ = 1'b1 // Counter overflow interrupt present
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic csr_re,
	input wire logic csr_we,
	input wire logic csr_sup,
	input wire logic [XLEN-1:0] csr_wdata,
	input wire trcc_evt_s evt,
	input wire logic recorder_halted_flag,
	output logic [XLEN-1:0] csr_rdata_q,
	output logic [63:0] ctrl_q,
	output trcc_out_s rec_q
);

	// ************************************************************
	// State
	// ************************************************************
	// All register state outside the filter in one record: the shared control word and
	// the read data latched on a read strobe
	typedef struct packed {
		logic [63:0] ctrl;
		logic [63:0] rdata;
	} trcc_st_s;

	trcc_st_s st_q; // Registered state
	trcc_st_s st_d; // Next state
	logic [63:0] wmask; // Fields the current write may change
	logic [63:0] wide_wdata; // Write data widened to the register
	logic [63:0] view; // Value seen by the current access

	// ************************************************************
	// Masks for the addressed view
	// ************************************************************
	// Build the writable set; the supervisor view and a narrow
	// register width both shrink it. Reserved, custom and absent
	// fields never enter the mask, so they keep their reset zero.
	function automatic logic [63:0] trcc_wmask(input logic sup);
		logic [63:0] m;
		m = TRCC_BASE_WMASK;
		if (HAS_OVF_IRQ) begin
			m = m | TRCC_LCOF_WMASK;
		end
		if (sup) begin
			m = m & ~TRCC_SUP_HIDE;
		end
		if (XLEN < TRCC_REG_W) begin
			m = m & TRCC_LOW_MASK;
		end
		return m;
	endfunction

	// Read view: the supervisor register is a masked window
	// onto the same storage, never a copy of its own
	function automatic logic [63:0] trcc_view(input logic sup, input logic [63:0] c);
		logic [63:0] v;
		v = c;
		if (sup) begin
			v = c & ~TRCC_SUP_HIDE;
		end
		return v;
	endfunction

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		st_d = st_q;
		wmask = trcc_wmask(csr_sup);
		wide_wdata = 64'(csr_wdata);
		view = trcc_view(csr_sup, st_q.ctrl);
		// A read returns the value before a same-cycle write,
		// which gives swap semantics for read-modify-write
		if (csr_re) begin
			st_d.rdata = view;
		end
		// Merge only writable fields; everything else holds
		if (csr_we) begin
			st_d.ctrl = (st_q.ctrl & ~wmask) | (wide_wdata & wmask);
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	// Synchronous reset clears every field to standard behaviour,
	// custom bits included
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q.ctrl <= TRCC_RESET;
			st_q.rdata <= 64'h0;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state flops
	assign csr_rdata_q = st_q.rdata[XLEN-1:0];
	assign ctrl_q = st_q.ctrl;

	// ************************************************************
	// Recorder filter
	// ************************************************************
	// The filter sees the stored word; its decision lags the event
	// by one cycle and a control write takes effect the cycle after
	trcc_filter u_filter (
		.clk(clk),
		.rst(rst),
		.ctrl(st_q.ctrl),
		.evt(evt),
		.recorder_halted_flag(recorder_halted_flag),
		.out_q(rec_q)
	);

	// ************************************************************
	// Checks
	// ************************************************************
	// Mode enables land exactly as written through the machine view
	a_mode_write: assert property (@(posedge clk) disable iff (rst)
		(csr_we && !csr_sup) |=> ctrl_q[2:0] == $past(csr_wdata[2:0]))
		else $error("mode enables not written");

	// Breakpoint freeze is always implemented and writable
	a_bp_frz_write: assert property (@(posedge clk) disable iff (rst)
		(csr_we && !csr_sup) |=> ctrl_q[TRCC_BIT_BP_FRZ] == $past(csr_wdata[TRCC_BIT_BP_FRZ]))
		else $error("breakpoint freeze not written");

	// Overflow freeze follows the write when the interrupt exists
	a_lcof_write: assert property (@(posedge clk) disable iff (rst)
		(HAS_OVF_IRQ && csr_we) |=>
		ctrl_q[TRCC_BIT_LCOFRZ] == $past(csr_wdata[TRCC_BIT_LCOFRZ]))
		else $error("overflow freeze not written");

	// Supervisor read never shows the hidden machine fields
	a_sup_hidden: assert property (@(posedge clk) disable iff (rst)
		(csr_re && csr_sup) |=> csr_rdata_q[TRCC_BIT_MACHINE] == 1'b0
		&& csr_rdata_q[TRCC_BIT_MTRAP] == 1'b0)
		else $error("hidden field visible in supervisor view");

	// Supervisor write leaves the hidden machine fields alone
	a_sup_keep: assert property (@(posedge clk) disable iff (rst)
		(csr_we && csr_sup) |=> $stable(ctrl_q[TRCC_BIT_MACHINE])
		&& $stable(ctrl_q[TRCC_BIT_MTRAP]))
		else $error("supervisor write reached machine field");

	// Supervisor read shows the shared machine state, masked
	a_sup_shared: assert property (@(posedge clk) disable iff (rst)
		(csr_re && csr_sup) |=>
		csr_rdata_q == $past(st_q.ctrl[XLEN-1:0] & ~TRCC_SUP_HIDE[XLEN-1:0]))
		else $error("supervisor view diverged from machine state");

	// Reserved and custom fields stay zero forever
	a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
		csr_we |=> (ctrl_q & ~(TRCC_BASE_WMASK | TRCC_LCOF_WMASK)) == 64'h0)
		else $error("reserved field changed");

	// A narrow hart cannot disturb the upper half
	a_upper_hold: assert property (@(posedge clk) disable iff (rst)
		(XLEN < TRCC_REG_W && csr_we) |=> $stable(ctrl_q[63:32]))
		else $error("upper half written by narrow hart");

	// Inhibit of direct calls is honoured by the filter one cycle on
	a_call_inhibit: assert property (@(posedge clk) disable iff (rst)
		(ctrl_q[TRCC_BIT_DIRCALL] && evt.kind == TRCC_K_DIRCALL) |=> !rec_q.record)
		else $error("inhibited direct call recorded");

	// Trap enable lets a machine trap through with machine mode off
	a_mtrap_record: assert property (@(posedge clk) disable iff (rst)
		(evt.valid && !recorder_halted_flag && evt.kind == TRCC_K_INTR
		&& evt.trap_tgt == TRCC_PRIV_M && ctrl_q[TRCC_BIT_MTRAP]
		&& !ctrl_q[TRCC_BIT_INTR_INH] && !ctrl_q[TRCC_BIT_RAS_EMU]) |=> rec_q.record)
		else $error("machine trap not recorded");

	// Supervisor mode off drops a branch taken in supervisor code
	a_super_off: assert property (@(posedge clk) disable iff (rst)
		(evt.valid && evt.priv == TRCC_PRIV_S && !ctrl_q[TRCC_BIT_SUPER]
		&& evt.kind == TRCC_K_TKBR) |=> !rec_q.record)
		else $error("branch recorded with supervisor mode off");

	// User mode on records an uninhibited taken branch
	a_user_on: assert property (@(posedge clk) disable iff (rst)
		(evt.valid && !recorder_halted_flag && evt.priv == TRCC_PRIV_U
		&& ctrl_q[TRCC_BIT_USER] && evt.kind == TRCC_K_TKBR
		&& !ctrl_q[TRCC_BIT_TKBR_INH] && !ctrl_q[TRCC_BIT_RAS_EMU]) |=> rec_q.record)
		else $error("user branch not recorded");

	// Machine mode on records an uninhibited taken branch
	a_mach_on: assert property (@(posedge clk) disable iff (rst)
		(evt.valid && !recorder_halted_flag && evt.priv == TRCC_PRIV_M
		&& ctrl_q[TRCC_BIT_MACHINE] && evt.kind == TRCC_K_TKBR
		&& !ctrl_q[TRCC_BIT_TKBR_INH] && !ctrl_q[TRCC_BIT_RAS_EMU]) |=> rec_q.record)
		else $error("machine branch not recorded");

	// Supervisor trap enable lets an interrupt into supervisor through
	a_strap_record: assert property (@(posedge clk) disable iff (rst)
		(evt.valid && !recorder_halted_flag && evt.kind == TRCC_K_INTR
		&& evt.trap_tgt == TRCC_PRIV_S && ctrl_q[TRCC_BIT_STRAP]
		&& !ctrl_q[TRCC_BIT_INTR_INH] && !ctrl_q[TRCC_BIT_RAS_EMU]) |=> rec_q.record)
		else $error("supervisor trap not recorded");

	// With neither enable a machine trap out of user code is dropped
	a_trap_off: assert property (@(posedge clk) disable iff (rst)
		(evt.kind == TRCC_K_EXC && evt.priv == TRCC_PRIV_U && evt.trap_tgt == TRCC_PRIV_M
		&& !ctrl_q[TRCC_BIT_USER] && !ctrl_q[TRCC_BIT_MTRAP]) |=> !rec_q.record)
		else $error("trap recorded with no enable");

	// Not-taken branches need their own enable
	a_ntbr_off: assert property (@(posedge clk) disable iff (rst)
		(evt.kind == TRCC_K_NTBR && !ctrl_q[TRCC_BIT_NTBR_EN])
		|=> !rec_q.record)
		else $error("not-taken branch recorded while off");

	// Enabled not-taken branch in an enabled mode is recorded
	a_ntbr_on: assert property (@(posedge clk) disable iff (rst)
		(evt.valid && !recorder_halted_flag && evt.kind == TRCC_K_NTBR
		&& evt.priv == TRCC_PRIV_U && ctrl_q[TRCC_BIT_USER]
		&& ctrl_q[TRCC_BIT_NTBR_EN] && !ctrl_q[TRCC_BIT_RAS_EMU]) |=> rec_q.record)
		else $error("not-taken branch not recorded");

	// Taken branch inhibit
	a_tkbr_inh: assert property (@(posedge clk) disable iff (rst)
		(evt.kind == TRCC_K_TKBR && ctrl_q[TRCC_BIT_TKBR_INH])
		|=> !rec_q.record)
		else $error("inhibited taken branch recorded");

	// Interrupt inhibit
	a_intr_inh: assert property (@(posedge clk) disable iff (rst)
		(evt.kind == TRCC_K_INTR && ctrl_q[TRCC_BIT_INTR_INH])
		|=> !rec_q.record)
		else $error("inhibited interrupt recorded");

	// Trap return inhibit
	a_tret_inh: assert property (@(posedge clk) disable iff (rst)
		(evt.kind == TRCC_K_TRET && ctrl_q[TRCC_BIT_TRET_INH])
		|=> !rec_q.record)
		else $error("inhibited trap return recorded");

	// Indirect call inhibit
	a_icall_inh: assert property (@(posedge clk) disable iff (rst)
		(evt.kind == TRCC_K_INDCALL && ctrl_q[TRCC_BIT_INDCALL])
		|=> !rec_q.record)
		else $error("inhibited indirect call recorded");

	// Unlinked jump inhibits
	a_jump_inh: assert property (@(posedge clk) disable iff (rst)
		((evt.kind == TRCC_K_INDJMP && ctrl_q[TRCC_BIT_INDJMP])
		|| (evt.kind == TRCC_K_DIRJMP && ctrl_q[TRCC_BIT_DIRJMP])) |=> !rec_q.record)
		else $error("inhibited jump recorded");

	// Co-routine swap and return inhibits
	a_swap_inh: assert property (@(posedge clk) disable iff (rst)
		((evt.kind == TRCC_K_CORSWAP && ctrl_q[TRCC_BIT_CORSWAP])
		|| (evt.kind == TRCC_K_RET && ctrl_q[TRCC_BIT_RET])) |=> !rec_q.record)
		else $error("inhibited swap or return recorded");

	// Other linked jump inhibits
	a_ljump_inh: assert property (@(posedge clk) disable iff (rst)
		((evt.kind == TRCC_K_INDLJMP && ctrl_q[TRCC_BIT_INDLJMP])
		|| (evt.kind == TRCC_K_DIRLJMP && ctrl_q[TRCC_BIT_DIRLJMP])) |=> !rec_q.record)
		else $error("inhibited linked jump recorded");

	// Stack emulation keeps nothing but calls
	a_ras_drop: assert property (@(posedge clk) disable iff (rst)
		(ctrl_q[TRCC_BIT_RAS_EMU] && evt.kind != TRCC_K_INDCALL
		&& evt.kind != TRCC_K_DIRCALL) |=> !rec_q.record)
		else $error("non-call recorded in stack emulation");

	// A qualifying return pops the newest call in stack emulation
	a_ras_pop: assert property (@(posedge clk) disable iff (rst)
		(evt.valid && !recorder_halted_flag && evt.kind == TRCC_K_RET
		&& evt.priv == TRCC_PRIV_U && ctrl_q[TRCC_BIT_USER]
		&& ctrl_q[TRCC_BIT_RAS_EMU]) |=> rec_q.ras_pop)
		else $error("return did not pop");

	// Outside stack emulation nothing is ever popped
	a_pop_no_ras: assert property (@(posedge clk) disable iff (rst)
		!ctrl_q[TRCC_BIT_RAS_EMU]
		|=> !rec_q.ras_pop)
		else $error("pop outside stack emulation");

	// Overflow interrupt into supervisor freezes when armed
	a_ovf_freeze: assert property (@(posedge clk) disable iff (rst)
		(evt.valid && evt.kind == TRCC_K_INTR && evt.local_counter_overflow_interrupt
		&& ctrl_q[TRCC_BIT_LCOFRZ] && evt.trap_tgt == TRCC_PRIV_S) |=> rec_q.freeze_set)
		else $error("overflow interrupt did not freeze");

	// Only a trap into supervisor or machine may freeze
	a_freeze_user: assert property (@(posedge clk) disable iff (rst)
		(!evt.valid || evt.trap_tgt == TRCC_PRIV_U)
		|=> !rec_q.freeze_set)
		else $error("freeze without a privileged trap");

	// Machine read returns the stored word as it stood at the strobe
	a_machine_read: assert property (@(posedge clk) disable iff (rst)
		(csr_re && !csr_sup)
		|=> csr_rdata_q == $past(ctrl_q[XLEN-1:0]))
		else $error("machine read mismatch");

	// The control word only moves on a write
	a_ctrl_hold: assert property (@(posedge clk) disable iff (rst)
		!csr_we
		|=> $stable(ctrl_q))
		else $error("control word changed without a write");

endmodule

/* File: core/trcc_pkg.sv */
// Shared constants, field positions and carrier types of the transfer record control block
//
// Functional notes
// - 64-bit software read/write machine control register
// - Bits 0..2 enable user, supervisor, machine recording
// - Bit 7 selects return stack emulation
// - Bit 9 records machine traps despite disabled mode
// - Bit 8 records supervisor traps despite disabled mode
// - Bit 11 freezes recorder on breakpoint traps
// - Bit 12 freezes recorder on counter overflow
// - Bits 33..35 inhibit exceptions, interrupts, trap returns
// - Bit 36 enables not-taken, 37 inhibits taken
// - Bits 40, 41 inhibit indirect, direct calls
// - Bits 42, 43 inhibit unlinked indirect, direct jumps
// - Bits 44, 45 inhibit coroutine swaps, returns
// - Bits 46, 47 inhibit other linked jumps
// - Custom bits 63..60 legal-only, zero is standard
// - Mode enables and breakpoint freeze always present
// - Absent fields read zero; present fields writable
// - Overflow freeze writable when overflow interrupt exists
// - Narrow register width cannot reach upper half
// - Supervisor view shares machine register state
// - Supervisor view bits 2 and 9 read zero
// - Other fields reachable through supervisor view
// - Stack emulation records calls, returns pop

package trcc_pkg;

	// ************************************************************
	// Field positions of the control register
	// ************************************************************
	localparam int TRCC_BIT_USER = 0;
	localparam int TRCC_BIT_SUPER = 1;
	localparam int TRCC_BIT_MACHINE = 2;
	localparam int TRCC_BIT_RAS_EMU = 7;
	localparam int TRCC_BIT_STRAP = 8;
	localparam int TRCC_BIT_MTRAP = 9;
	localparam int TRCC_BIT_BP_FRZ = 11;
	localparam int TRCC_BIT_LCOFRZ = 12;
	localparam int TRCC_BIT_EXC_INH = 33;
	localparam int TRCC_BIT_INTR_INH = 34;
	localparam int TRCC_BIT_TRET_INH = 35;
	localparam int TRCC_BIT_NTBR_EN = 36;
	localparam int TRCC_BIT_TKBR_INH = 37;
	localparam int TRCC_BIT_INDCALL = 40;
	localparam int TRCC_BIT_DIRCALL = 41;
	localparam int TRCC_BIT_INDJMP = 42;
	localparam int TRCC_BIT_DIRJMP = 43;
	localparam int TRCC_BIT_CORSWAP = 44;
	localparam int TRCC_BIT_RET = 45;
	localparam int TRCC_BIT_INDLJMP = 46;
	localparam int TRCC_BIT_DIRLJMP = 47;

	// ************************************************************
	// Widths, reset value and masks
	// ************************************************************
	localparam int TRCC_REG_W = 64;
	localparam int TRCC_HALF_W = 32;
	localparam logic [63:0] TRCC_RESET = 64'h0;
	// Always-writable fields: modes, stack emulation, trap enables, breakpoint freeze, not-taken enable, inhibits
	localparam logic [63:0] TRCC_BASE_WMASK = 64'h0000_FF3E_0000_0B87;
	// Overflow freeze, present only with the overflow interrupt
	localparam logic [63:0] TRCC_LCOF_WMASK = 64'h0000_0000_0000_1000;
	// Fields hidden from the supervisor view
	localparam logic [63:0] TRCC_SUP_HIDE = 64'h0000_0000_0000_0204;
	// Part of the register reachable with a narrow register width
	localparam logic [63:0] TRCC_LOW_MASK = 64'h0000_0000_FFFF_FFFF;

	// ************************************************************
	// Privilege encodings
	// ************************************************************
	localparam logic [1:0] TRCC_PRIV_U = 2'h0;
	localparam logic [1:0] TRCC_PRIV_S = 2'h1;
	localparam logic [1:0] TRCC_PRIV_M = 2'h3;

	// Kinds of control transfer offered to the recorder
	typedef enum logic [3:0] {
		TRCC_K_EXC, TRCC_K_INTR, TRCC_K_TRET, TRCC_K_NTBR, TRCC_K_TKBR,
		TRCC_K_INDCALL, TRCC_K_DIRCALL, TRCC_K_INDJMP, TRCC_K_DIRJMP,
		TRCC_K_CORSWAP, TRCC_K_RET, TRCC_K_INDLJMP, TRCC_K_DIRLJMP
	} trcc_kind_e;

	// One retired transfer from the hart
	typedef struct packed {
		logic valid;
		trcc_kind_e kind;
		logic [1:0] priv;
		logic [1:0] trap_tgt;
		logic breakpoint;
		logic local_counter_overflow_interrupt;
	} trcc_evt_s;

	// Decision handed to the record buffer
	typedef struct packed {
		logic record;
		logic ras_pop;
		logic freeze_set;
	} trcc_out_s;

endpackage

/* File: core/trcc_filter.sv */
// Transfer qualification, stack emulation and freeze decision
`timescale 1ns/100ps

module trcc_filter
	import trcc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [63:0] ctrl,
	input wire trcc_evt_s evt,
	input wire logic recorder_halted_flag,
	output trcc_out_s out_q
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		trcc_out_s out;
	} trcc_fst_s;

	trcc_fst_s st_q; // Registered decision
	trcc_fst_s st_d; // Next decision

	// Inhibit lookup by transfer kind
	function automatic logic trcc_kind_ok(input logic [63:0] c, input trcc_kind_e k);
		logic ok;
		ok = 1'b0;
		unique case (k)
			TRCC_K_EXC: ok = !c[TRCC_BIT_EXC_INH];
			TRCC_K_INTR: ok = !c[TRCC_BIT_INTR_INH];
			TRCC_K_TRET: ok = !c[TRCC_BIT_TRET_INH];
			TRCC_K_NTBR: ok = c[TRCC_BIT_NTBR_EN];
			TRCC_K_TKBR: ok = !c[TRCC_BIT_TKBR_INH];
			TRCC_K_INDCALL: ok = !c[TRCC_BIT_INDCALL];
			TRCC_K_DIRCALL: ok = !c[TRCC_BIT_DIRCALL];
			TRCC_K_INDJMP: ok = !c[TRCC_BIT_INDJMP];
			TRCC_K_DIRJMP: ok = !c[TRCC_BIT_DIRJMP];
			TRCC_K_CORSWAP: ok = !c[TRCC_BIT_CORSWAP];
			TRCC_K_RET: ok = !c[TRCC_BIT_RET];
			TRCC_K_INDLJMP: ok = !c[TRCC_BIT_INDLJMP];
			TRCC_K_DIRLJMP: ok = !c[TRCC_BIT_DIRLJMP];
			default: ok = 1'b0; // Unused kind codes are never recorded
		endcase
		return ok;
	endfunction

	// ************************************************************
	// Decision logic
	// ************************************************************
	always_comb begin
		logic mode_ok;
		logic is_trap;
		logic to_os;
		logic is_call;
		mode_ok = 1'b0;
		is_trap = (evt.kind == TRCC_K_EXC) || (evt.kind == TRCC_K_INTR);
		to_os = (evt.trap_tgt == TRCC_PRIV_M) || (evt.trap_tgt == TRCC_PRIV_S);
		is_call = (evt.kind == TRCC_K_INDCALL) || (evt.kind == TRCC_K_DIRCALL);
		st_d = st_q;
		// Mode filter on the privilege the transfer left
		unique case (evt.priv)
			TRCC_PRIV_U: mode_ok = ctrl[TRCC_BIT_USER];
			TRCC_PRIV_S: mode_ok = ctrl[TRCC_BIT_SUPER];
			TRCC_PRIV_M: mode_ok = ctrl[TRCC_BIT_MACHINE];
			default: mode_ok = 1'b0; // Reserved privilege code
		endcase
		// Traps into a mode whose trap enable is set count even with the mode filter off
		if (is_trap && evt.trap_tgt == TRCC_PRIV_M && ctrl[TRCC_BIT_MTRAP]) begin
			mode_ok = 1'b1;
		end
		if (is_trap && evt.trap_tgt == TRCC_PRIV_S && ctrl[TRCC_BIT_STRAP]) begin
			mode_ok = 1'b1;
		end
		st_d.out.record = 1'b0;
		st_d.out.ras_pop = 1'b0;
		st_d.out.freeze_set = 1'b0;
		if (evt.valid && !recorder_halted_flag && mode_ok) begin
			if (ctrl[TRCC_BIT_RAS_EMU]) begin
				// Stack emulation: calls push, returns pop, rest dropped
				st_d.out.record = is_call && trcc_kind_ok(ctrl, evt.kind);
				st_d.out.ras_pop = (evt.kind == TRCC_K_RET);
			end else begin
				st_d.out.record = trcc_kind_ok(ctrl, evt.kind);
			end
		end
		// Freeze requests act even while recording is filtered out
		if (evt.valid && to_os) begin
			if (evt.kind == TRCC_K_EXC && evt.breakpoint && ctrl[TRCC_BIT_BP_FRZ]) begin
				st_d.out.freeze_set = 1'b1;
			end
			if (evt.kind == TRCC_K_INTR && evt.local_counter_overflow_interrupt
				&& ctrl[TRCC_BIT_LCOFRZ]) begin
				st_d.out.freeze_set = 1'b1;
			end
		end
	end

	// Register the decision
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign out_q = st_q.out;

	// ************************************************************
	// Checks
	// ************************************************************
	a_bp_freeze: assert property (@(posedge clk) disable iff (rst)
		(evt.valid && evt.kind == TRCC_K_EXC && evt.breakpoint && ctrl[TRCC_BIT_BP_FRZ]
		&& evt.trap_tgt == TRCC_PRIV_M) |=> out_q.freeze_set)
		else $error("breakpoint trap did not freeze");

	a_exc_inhibit: assert property (@(posedge clk) disable iff (rst)
		(evt.kind == TRCC_K_EXC && ctrl[TRCC_BIT_EXC_INH]) |=> !out_q.record)
		else $error("inhibited exception recorded");

	a_ras_no_ret: assert property (@(posedge clk) disable iff (rst)
		(ctrl[TRCC_BIT_RAS_EMU] && evt.kind == TRCC_K_RET) |=> !out_q.record)
		else $error("return recorded in stack emulation");

	a_halt_blocks: assert property (@(posedge clk) disable iff (rst)
		(recorder_halted_flag || !evt.valid) |=> !out_q.record && !out_q.ras_pop)
		else $error("record while halted or idle");

endmodule

/* File: tb/trcc_tb.sv */
// Self-checking bench for the transfer record control registers and recorder filter
`timescale 1ns/100ps

`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_total++; \
	$display("[FAIL] %s exp=%h got=%h", nm, ex, got); end end

module tb;
	import trcc_pkg::*;

	// ************************************************************
	// Stimulus and observation signals
	// ************************************************************
	logic clk = 1'b0;
	logic rst = 1'b1; // Held for five cycles at start
	logic csr_re = 1'b0;
	logic csr_we = 1'b0;
	logic csr_sup = 1'b0;
	logic [63:0] csr_wdata = 64'h0;
	trcc_evt_s evt = '0;
	logic recorder_halted_flag = 1'b0;
	logic [63:0] csr_rdata_q;
	logic [63:0] ctrl_q;
	trcc_out_s rec_q;
	logic [31:0] rdata32; // Narrow instance sees only the low half of write data
	logic [63:0] ctrl32;
	int err_total = 0;
	int comparisons = 0;
	logic [63:0] rv;

	// One register access row: view, data, readback through each view
	typedef struct {logic s; logic [63:0] d; logic [63:0] m; logic [63:0] v;} trcc_tb_reg_s;
	// One event row: control word, event fields, halted, {record, pop, freeze}
	typedef struct {logic [63:0] c; trcc_kind_e k; logic [1:0] p; logic [1:0] t;
		logic b; logic l; logic h; logic [2:0] e;} trcc_tb_evt_s;

	trcc_tb_reg_s rr[7] = '{
		'{1'b0, '1, 64'h0000_FF3E_0000_1B87, 64'h0000_FF3E_0000_1983},
		'{1'b1, 64'h0, 64'h204, 64'h0},
		'{1'b1, '1, 64'h0000_FF3E_0000_1B87, 64'h0000_FF3E_0000_1983},
		'{1'b0, 64'h0, 64'h0, 64'h0},
		'{1'b1, '1, 64'h0000_FF3E_0000_1983, 64'h0000_FF3E_0000_1983},
		'{1'b0, 64'hF000_0000_0000_0000, 64'h0, 64'h0},
		'{1'b0, 64'h807, 64'h807, 64'h803}};

	trcc_tb_evt_s er[18] = '{
		'{64'h1, TRCC_K_TKBR, TRCC_PRIV_U, TRCC_PRIV_U, 0, 0, 0, 3'b100},
		'{64'h1, TRCC_K_TKBR, TRCC_PRIV_S, TRCC_PRIV_U, 0, 0, 0, 3'b000},
		'{64'h2, TRCC_K_TKBR, TRCC_PRIV_S, TRCC_PRIV_U, 0, 0, 0, 3'b100},
		'{64'h4, TRCC_K_TKBR, TRCC_PRIV_M, TRCC_PRIV_U, 0, 0, 0, 3'b100},
		'{64'h0000_0020_0000_0001, TRCC_K_TKBR, TRCC_PRIV_U, TRCC_PRIV_U, 0, 0, 0, 3'b000},
		'{64'h1, TRCC_K_NTBR, TRCC_PRIV_U, TRCC_PRIV_U, 0, 0, 0, 3'b000},
		'{64'h0000_0010_0000_0001, TRCC_K_NTBR, TRCC_PRIV_U, TRCC_PRIV_U, 0, 0, 0, 3'b100},
		'{64'h200, TRCC_K_EXC, TRCC_PRIV_U, TRCC_PRIV_M, 0, 0, 0, 3'b100},
		'{64'h200, TRCC_K_INTR, TRCC_PRIV_U, TRCC_PRIV_M, 0, 0, 0, 3'b100},
		'{64'h0, TRCC_K_EXC, TRCC_PRIV_U, TRCC_PRIV_M, 0, 0, 0, 3'b000},
		'{64'h100, TRCC_K_INTR, TRCC_PRIV_U, TRCC_PRIV_S, 0, 0, 0, 3'b100},
		'{64'h81, TRCC_K_DIRCALL, TRCC_PRIV_U, TRCC_PRIV_U, 0, 0, 0, 3'b100},
		'{64'h81, TRCC_K_TKBR, TRCC_PRIV_U, TRCC_PRIV_U, 0, 0, 0, 3'b000},
		'{64'h0000_2000_0000_0081, TRCC_K_RET, TRCC_PRIV_U, TRCC_PRIV_U, 0, 0, 0, 3'b010},
		'{64'h800, TRCC_K_EXC, TRCC_PRIV_U, TRCC_PRIV_M, 1, 0, 0, 3'b001},
		'{64'h800, TRCC_K_EXC, TRCC_PRIV_U, TRCC_PRIV_U, 1, 0, 0, 3'b000},
		'{64'h1000, TRCC_K_INTR, TRCC_PRIV_U, TRCC_PRIV_S, 0, 1, 0, 3'b001},
		'{64'h1, TRCC_K_TKBR, TRCC_PRIV_U, TRCC_PRIV_U, 0, 0, 1, 3'b000}};

	// Kinds paired with the bit that inhibits each of them
	trcc_kind_e ik[11] = '{TRCC_K_EXC, TRCC_K_INTR, TRCC_K_TRET, TRCC_K_INDCALL,
		TRCC_K_DIRCALL, TRCC_K_INDJMP, TRCC_K_DIRJMP, TRCC_K_CORSWAP, TRCC_K_RET,
		TRCC_K_INDLJMP, TRCC_K_DIRLJMP};
	int ib[11] = '{TRCC_BIT_EXC_INH, TRCC_BIT_INTR_INH, TRCC_BIT_TRET_INH, TRCC_BIT_INDCALL,
		TRCC_BIT_DIRCALL, TRCC_BIT_INDJMP, TRCC_BIT_DIRJMP, TRCC_BIT_CORSWAP, TRCC_BIT_RET,
		TRCC_BIT_INDLJMP, TRCC_BIT_DIRLJMP};

	// ************************************************************
	// Design instances: full width and narrow width side by side
	// ************************************************************
	trcc_csr #(.XLEN(64), .HAS_OVF_IRQ(1'b1)) dut (.clk(clk), .rst(rst), .csr_re(csr_re),
		.csr_we(csr_we), .csr_sup(csr_sup), .csr_wdata(csr_wdata), .evt(evt),
		.recorder_halted_flag(recorder_halted_flag), .csr_rdata_q(csr_rdata_q),
		.ctrl_q(ctrl_q), .rec_q(rec_q));
	trcc_csr #(.XLEN(32), .HAS_OVF_IRQ(1'b1)) dut32 (.clk(clk), .rst(rst), .csr_re(csr_re),
		.csr_we(csr_we), .csr_sup(csr_sup), .csr_wdata(csr_wdata[31:0]), .evt(evt),
		.recorder_halted_flag(recorder_halted_flag), .csr_rdata_q(rdata32),
		.ctrl_q(ctrl32), .rec_q());

	// Clock generator, 50 ns period
	initial begin
		forever #25 clk = ~clk;
	end

	// Each access and event task is entered and left one step after a rising edge
	task automatic wr(input logic s, input logic [63:0] d);
		csr_sup = s;
		csr_wdata = d;
		csr_we = 1'b1;
		@(posedge clk);
		#1 csr_we = 1'b0;
	endtask

	// Read data is registered on the strobe edge, so it is settled one step later
	task automatic rd(input logic s, output logic [63:0] d);
		csr_sup = s;
		csr_re = 1'b1;
		@(posedge clk);
		#1 csr_re = 1'b0;
		d = csr_rdata_q;
	endtask

	// Load the control word, offer one event, check the decision one cycle later
	task automatic ev(input trcc_tb_evt_s r);
		wr(1'b0, r.c);
		evt = '{valid: 1'b1, kind: r.k, priv: r.p, trap_tgt: r.t, breakpoint: r.b,
			local_counter_overflow_interrupt: r.l};
		recorder_halted_flag = r.h;
		@(posedge clk);
		#1 evt.valid = 1'b0;
		recorder_halted_flag = 1'b0;
		`CHK("rec_q", r.e, rec_q)
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Watchdog: a hang counts as a mismatch
	initial begin
		#(50 * 5000);
		err_total++;
		final_report();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
		`CHK("ctrl_q reset", 64'h0, ctrl_q)
		// Register rows: write through one view, read back through both
		foreach (rr[i]) begin
			wr(rr[i].s, rr[i].d);
			rd(1'b0, rv);
			`CHK("machine view", rr[i].m, rv)
			rd(1'b1, rv);
			`CHK("supervisor view", rr[i].v, rv)
			`CHK("narrow read", rr[i].v[31:0], rdata32)
			`CHK("ctrl_q", rr[i].m, ctrl_q)
			`CHK("narrow ctrl", {32'h0, rr[i].m[31:0]}, ctrl32)
		end
		// Event rows
		foreach (er[i]) begin
			ev(er[i]);
		end
		// Each inhibit bit except the taken-branch one: recorded without it, dropped with it
		foreach (ik[i]) begin
			ev('{64'h1, ik[i], TRCC_PRIV_U, TRCC_PRIV_U, 0, 0, 0, 3'b100});
			ev('{64'h1 | (64'h1 << ib[i]), ik[i], TRCC_PRIV_U, TRCC_PRIV_U, 0, 0, 0, 3'b000});
		end
		// Back-to-back events, then the pulse must drop
		@(posedge clk);
		#1 evt = '{valid: 1'b1, kind: TRCC_K_TKBR, priv: TRCC_PRIV_U, trap_tgt: 2'h0,
			breakpoint: 1'b0, local_counter_overflow_interrupt: 1'b0};
		@(posedge clk);
		#1 evt.kind = TRCC_K_NTBR;
		`CHK("rec_q first", 3'b100, rec_q)
		@(posedge clk);
		#1 evt.valid = 1'b0;
		`CHK("rec_q second", 3'b000, rec_q)
		@(posedge clk);
		#1 `CHK("rec_q idle", 3'b000, rec_q)
		// Read and write in one cycle: read sees the old value
		wr(1'b0, 64'h87);
		@(posedge clk);
		#1 csr_we = 1'b1;
		csr_re = 1'b1;
		csr_wdata = 64'h0;
		@(posedge clk);
		#1 csr_we = 1'b0;
		csr_re = 1'b0;
		`CHK("read old", 64'h87, csr_rdata_q)
		`CHK("write new", 64'h0, ctrl_q)
		// Reset in mid-run clears the shared word and the read data
		wr(1'b0, 64'h0000_FF3E_0000_1B87);
		rd(1'b0, rv);
		rst = 1'b1;
		@(posedge clk);
		#1 rst = 1'b0;
		`CHK("ctrl_q rst", 64'h0, ctrl_q)
		`CHK("rdata rst", 64'h0, csr_rdata_q)
		final_report();
	end
endmodule
